/* rtl/ldc_consts.svh */
// Constants for the display memory and scan controller.
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

`define LDC_COLUMNS            132
`define LDC_PAGES              8
`define LDC_ROWS               65
`define LDC_COMMONS            64
`define LDC_INDICATOR_PAGE     4'h8
`define LDC_LAST_COLUMN        8'h83
`define LDC_LAST_LINE          7'h40
`define LDC_LAST_COMMON        7'h3F
`define LDC_MAX_CONTRAST       6'h3F
`define LDC_FIFO_DEPTH         8
`define LDC_FIFO_WIDTH         10

`define LDC_OSC_DIVIDE         10'h190

`define LDC_CMD_PAGE_MASK      8'hF0
`define LDC_CMD_PAGE_CODE      8'hB0
`define LDC_CMD_COLHI_MASK     8'hF0
`define LDC_CMD_COLHI_CODE     8'h10
`define LDC_CMD_COLLO_MASK     8'hF0
`define LDC_CMD_COLLO_CODE     8'h00
`define LDC_CMD_START_MASK     8'hC0
`define LDC_CMD_START_CODE     8'h40
`define LDC_CMD_RATIO_MASK     8'hF8
`define LDC_CMD_RATIO_CODE     8'h20
`define LDC_CMD_COMDIR_MASK    8'hF7
`define LDC_CMD_COMDIR_CODE    8'hC0
`define LDC_CMD_TOGGLE_MASK    8'hFE
`define LDC_CMD_SEGDIR_CODE    8'hA0
`define LDC_CMD_ALLON_CODE     8'hA4
`define LDC_CMD_INVERSE_CODE   8'hA6
`define LDC_CMD_DISPON_CODE    8'hAE
`define LDC_CMD_VOLUME_CODE    8'h81

`define LDC_RST_PAGE           4'h0
`define LDC_RST_COLUMN         8'h00
`define LDC_RST_START          6'h00
`define LDC_RST_VOLUME         6'h20
`define LDC_RST_RATIO          3'h4

`endif

/* rtl/ldc_pkg.sv */
// Types shared by the display memory and scan controller.
package ldc_pkg;

    typedef enum logic [1:0] {
        LDC_ACC_NONE,
        LDC_ACC_WRITE,
        LDC_ACC_READ
    } ldc_access_type;

    typedef logic [7:0] ldc_byte_type;

endpackage

/* rtl/ldc_fifo.sv */
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module ldc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // Filling side.
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_reg [0:DEPTH-1];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      rdPtr_reg;
    logic             push;
    logic             pop;

    assign inReady  = (wrPtr_reg[AW] == rdPtr_reg[AW]) || (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]);
    assign outValid = (wrPtr_reg != rdPtr_reg);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = store_reg[rdPtr_reg[AW-1:0]];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= '0;
        end else if (push) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdPtr_reg <= '0;
        end else if (pop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            store_reg[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

endmodule

/* rtl/ldc_display.sv */
// Display memory, host command path and scan timing of the dot-matrix driver.
//
// Functional notes
// - Memory holds 65 rows by 132 column bits.
// - Access targets current page and column byte.
// - Byte bits map to vertical rows.
// - Host access never disturbs the scan-out.
// - Page changes only by its set command.
// - Page 8 stores only data bit zero.
// - Column advances by one per data access.
// - Column increment stops at 83 hex.
// - Segment direction bit reverses column mapping.
// - Start line shows on common 0 or 63.
// - Scan covers 65 rows from start line.
// - Display mode commands touch only the latch.
// - Oscillator runs only with both selects high.
// - Common direction selects scan order.
// - Display clock steps line and loads latch.
// - Polarity signal toggles once per frame, at the line 64 wrap.
// - Contrast level is 63 minus register.
// - Three-bit ratio register selects gain step; resistor select low forces gain step to zero.
// - Resistor select low disables internal divider.
`timescale 1ns/10ps
`include "ldc_consts.svh"
module ldc_display
    import ldc_pkg::*;
(
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         arst_n,
    // Host command and data port.
    input  wire logic         hostValid,
    output logic              hostReady,
    input  wire logic         hostIsData,
    input  wire logic         hostIsRead,
    input  wire logic [7:0]   hostWrData,
    output logic      [7:0]   hostRdData,
    output logic              hostRdValid,
    // Clock selection pins.
    input  wire logic         masterSelectInput,
    input  wire logic         internalClockSelect,
    input  wire logic         externalDisplayClockPin,
    output logic              oscillatorRunning,
    // Driver outputs.
    output logic [131:0]      segmentOutput,
    output logic [6:0]        commonIndex,
    output logic              lineStrobe,
    output logic              drivePolaritySignal,
    // Regulator settings.
    input  wire logic         internalResistorSelect,
    output logic [5:0]        contrastVolumeSetting,
    output logic [5:0]        contrastLevel,
    output logic [2:0]        regulatorRatioSetting,
    output logic [2:0]        regulatorGainStep,
    output logic              internalDividerEnable
);

    // Command queue between the host pins and the command processor.
    logic [9:0]      fifoIn;
    logic [9:0]      fifoOut;
    logic            fifoOutValid;
    logic            fifoOutReady;
    logic            cmdFire;
    logic            fifoIsData;
    logic            fifoIsRead;
    ldc_byte_type    fifoByte;

    // Display memory.
    logic [7:0]      pageMem_reg [0:`LDC_PAGES-1][0:`LDC_COLUMNS-1];
    logic            indicatorMem_reg [0:`LDC_COLUMNS-1];

    // Addressing.
    logic [3:0]      page_reg;
    logic [7:0]      column_reg;
    logic [7:0]      column_next;
    logic            columnInRange;
    logic            pageInRange;
    ldc_access_type  access;
    ldc_byte_type    readByte;

    // Display options.
    logic            segReverse_reg;
    logic            comReverse_reg;
    logic            inverse_reg;
    logic            displayOn_reg;
    logic            allOn_reg;
    logic [5:0]      startLine_reg;
    logic [5:0]      volume_reg;
    logic            volumePending_reg;
    logic [2:0]      ratio_reg;

    // Display clock.
    logic [9:0]      oscCount_reg;
    logic            oscTick;
    logic            extClockPrev_reg;
    logic            dispTick;

    // Scan.
    logic [6:0]      lineCount_reg;
    logic [6:0]      rowSum;
    logic [6:0]      rowAddr;
    logic [131:0]    rowBits;
    logic [131:0]    rowShaped;
    logic [131:0]    segLatch_reg;
    logic [6:0]      common_reg;
    logic            lineStrobe_reg;
    logic            polarity_reg;
    logic [7:0]      rdData_reg;
    logic            rdValid_reg;

    // Command decode.
    logic            isPageCmd;
    logic            isColHiCmd;
    logic            isColLoCmd;
    logic            isStartCmd;
    logic            isRatioCmd;
    logic            isComDirCmd;
    logic            isSegDirCmd;
    logic            isAllOnCmd;
    logic            isInverseCmd;
    logic            isDispOnCmd;
    logic            isVolumeCmd;
    logic            cmdTaken;

    assign fifoIn = {hostIsData, hostIsRead, hostWrData};

    ldc_fifo #(
        .WIDTH (`LDC_FIFO_WIDTH),
        .DEPTH (`LDC_FIFO_DEPTH)
    ) cmdQueue (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .inValid  (hostValid),
        .inReady  (hostReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    // The processor yields the cycle in which the scan loads a row, so host traffic backs up in the queue.
    assign fifoOutReady = !dispTick;
    assign cmdFire      = fifoOutValid && fifoOutReady;
    assign fifoIsData   = fifoOut[9];
    assign fifoIsRead   = fifoOut[8];
    assign fifoByte     = fifoOut[7:0];

    // The next command byte after the volume command is its operand and is never decoded.
    assign cmdTaken     = cmdFire && !fifoIsData && !volumePending_reg;
    assign isPageCmd    = cmdTaken && ((fifoByte & `LDC_CMD_PAGE_MASK) == `LDC_CMD_PAGE_CODE);
    assign isColHiCmd   = cmdTaken && ((fifoByte & `LDC_CMD_COLHI_MASK) == `LDC_CMD_COLHI_CODE);
    assign isColLoCmd   = cmdTaken && ((fifoByte & `LDC_CMD_COLLO_MASK) == `LDC_CMD_COLLO_CODE);
    assign isStartCmd   = cmdTaken && ((fifoByte & `LDC_CMD_START_MASK) == `LDC_CMD_START_CODE);
    assign isRatioCmd   = cmdTaken && ((fifoByte & `LDC_CMD_RATIO_MASK) == `LDC_CMD_RATIO_CODE);
    assign isComDirCmd  = cmdTaken && ((fifoByte & `LDC_CMD_COMDIR_MASK) == `LDC_CMD_COMDIR_CODE);
    assign isSegDirCmd  = cmdTaken && ((fifoByte & `LDC_CMD_TOGGLE_MASK) == `LDC_CMD_SEGDIR_CODE);
    assign isAllOnCmd   = cmdTaken && ((fifoByte & `LDC_CMD_TOGGLE_MASK) == `LDC_CMD_ALLON_CODE);
    assign isInverseCmd = cmdTaken && ((fifoByte & `LDC_CMD_TOGGLE_MASK) == `LDC_CMD_INVERSE_CODE);
    assign isDispOnCmd  = cmdTaken && ((fifoByte & `LDC_CMD_TOGGLE_MASK) == `LDC_CMD_DISPON_CODE);
    assign isVolumeCmd  = cmdTaken && (fifoByte == `LDC_CMD_VOLUME_CODE);

    // Data access classification.
    assign pageInRange   = (page_reg <= `LDC_INDICATOR_PAGE);
    assign columnInRange = (column_reg <= `LDC_LAST_COLUMN);

    always_comb begin
        access = LDC_ACC_NONE;
        if (cmdFire && fifoIsData && columnInRange && pageInRange) begin
            access = fifoIsRead ? LDC_ACC_READ : LDC_ACC_WRITE;
        end
    end

    always_comb begin
        column_next = column_reg;
        if (access != LDC_ACC_NONE && column_reg != `LDC_LAST_COLUMN) begin
            column_next = column_reg + 8'h01;
        end
    end

    // Page address only follows its own command.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            page_reg <= `LDC_RST_PAGE;
        end else if (isPageCmd) begin
            page_reg <= fifoByte[3:0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            column_reg <= `LDC_RST_COLUMN;
        end else if (isColHiCmd) begin
            column_reg <= {fifoByte[3:0], column_reg[3:0]};
        end else if (isColLoCmd) begin
            column_reg <= {column_reg[7:4], fifoByte[3:0]};
        end else begin
            column_reg <= column_next;
        end
    end

    // Host writes land in the byte chosen by page and column.
    always_ff @(posedge mclk) begin
        if (access == LDC_ACC_WRITE) begin
            if (page_reg == `LDC_INDICATOR_PAGE) begin
                indicatorMem_reg[column_reg] <= fifoByte[0];
            end else begin
                pageMem_reg[page_reg[2:0]][column_reg] <= fifoByte;
            end
        end
    end

    always_comb begin
        readByte = 8'h00;
        if (columnInRange) begin
            if (page_reg == `LDC_INDICATOR_PAGE) begin
                readByte = {7'h00, indicatorMem_reg[column_reg]};
            end else if (pageInRange) begin
                readByte = pageMem_reg[page_reg[2:0]][column_reg];
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_reg  <= 8'h00;
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= cmdFire && fifoIsData && fifoIsRead;
            if (cmdFire && fifoIsData && fifoIsRead) begin
                rdData_reg <= readByte;
            end
        end
    end

    // Display option settings.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            segReverse_reg <= 1'b0;
            comReverse_reg <= 1'b0;
            inverse_reg    <= 1'b0;
            displayOn_reg  <= 1'b0;
            allOn_reg      <= 1'b0;
        end else begin
            if (isSegDirCmd) begin
                segReverse_reg <= fifoByte[0];
            end
            if (isComDirCmd) begin
                comReverse_reg <= fifoByte[3];
            end
            if (isInverseCmd) begin
                inverse_reg <= fifoByte[0];
            end
            if (isDispOnCmd) begin
                displayOn_reg <= fifoByte[0];
            end
            if (isAllOnCmd) begin
                allOn_reg <= fifoByte[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            startLine_reg <= `LDC_RST_START;
        end else if (isStartCmd) begin
            startLine_reg <= fifoByte[5:0];
        end
    end

    // Regulator settings.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            volume_reg        <= `LDC_RST_VOLUME;
            volumePending_reg <= 1'b0;
        end else if (cmdFire && !fifoIsData) begin
            if (volumePending_reg) begin
                volume_reg        <= fifoByte[5:0];
                volumePending_reg <= 1'b0;
            end else begin
                volumePending_reg <= isVolumeCmd;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ratio_reg <= `LDC_RST_RATIO;
        end else if (isRatioCmd) begin
            ratio_reg <= fifoByte[2:0];
        end
    end

    // Display clock source.
    assign oscillatorRunning = masterSelectInput && internalClockSelect;
    assign oscTick           = oscillatorRunning && (oscCount_reg == `LDC_OSC_DIVIDE - 10'h001);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            oscCount_reg <= 10'h000;
        end else if (!oscillatorRunning || oscTick) begin
            oscCount_reg <= 10'h000;
        end else begin
            oscCount_reg <= oscCount_reg + 10'h001;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            extClockPrev_reg <= 1'b0;
        end else begin
            extClockPrev_reg <= externalDisplayClockPin;
        end
    end

    assign dispTick = oscillatorRunning ? oscTick : (externalDisplayClockPin && !extClockPrev_reg);

    // Scan row selection wraps inside the 65 rows counted from the start line.
    assign rowSum  = {1'b0, startLine_reg} + lineCount_reg;
    assign rowAddr = (rowSum > `LDC_LAST_LINE) ? rowSum - 7'd65 : rowSum;

    // The scan read path is separate from the host port and only reads memory.
    genvar col;
    generate
        for (col = 0; col < `LDC_COLUMNS; col = col + 1) begin : gScan
            assign rowBits[col] = (rowAddr == `LDC_LAST_LINE) ? indicatorMem_reg[col]
                                : pageMem_reg[rowAddr[5:3]][col][rowAddr[2:0]];
            assign rowShaped[col] = displayOn_reg
                                  && (allOn_reg || (inverse_reg ^ rowBits[segReverse_reg ? 131 - col : col]));
        end
    endgenerate

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lineCount_reg <= 7'h00;
            polarity_reg  <= 1'b0;
        end else if (dispTick) begin
            if (lineCount_reg == `LDC_LAST_LINE) begin
                lineCount_reg <= 7'h00;
                polarity_reg  <= !polarity_reg;
            end else begin
                lineCount_reg <= lineCount_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            segLatch_reg   <= '0;
            common_reg     <= 7'h00;
            lineStrobe_reg <= 1'b0;
        end else begin
            lineStrobe_reg <= dispTick;
            if (dispTick) begin
                segLatch_reg <= rowShaped;
                if (lineCount_reg == `LDC_LAST_LINE || !comReverse_reg) begin
                    common_reg <= lineCount_reg;
                end else begin
                    common_reg <= `LDC_LAST_COMMON - lineCount_reg;
                end
            end
        end
    end

    // Output assignments.
    assign segmentOutput         = segLatch_reg;
    assign commonIndex           = common_reg;
    assign lineStrobe            = lineStrobe_reg;
    assign drivePolaritySignal   = polarity_reg;
    assign hostRdData            = rdData_reg;
    assign hostRdValid           = rdValid_reg;
    assign contrastVolumeSetting = volume_reg;
    assign contrastLevel         = `LDC_MAX_CONTRAST - volume_reg;
    assign regulatorRatioSetting = ratio_reg;
    assign internalDividerEnable = internalResistorSelect;
    assign regulatorGainStep     = internalResistorSelect ? ratio_reg : 3'h0;

endmodule

/* sim/ldc_display_monitor.sv */
// Port checker for the display controller, bound to its top module.
`timescale 1ns/10ps
module ldc_display_monitor (
    // Clock and reset.
    input wire logic       mclk,
    input wire logic       arst_n,
    // Host port.
    input wire logic       hostValid,
    input wire logic       hostReady,
    input wire logic       hostIsData,
    input wire logic       hostIsRead,
    input wire logic [7:0] hostRdData,
    input wire logic       hostRdValid,
    // Clock selection and scan.
    input wire logic       masterSelectInput,
    input wire logic       internalClockSelect,
    input wire logic       externalDisplayClockPin,
    input wire logic       oscillatorRunning,
    input wire logic [6:0] commonIndex,
    input wire logic       lineStrobe,
    input wire logic       drivePolaritySignal,
    // Regulator settings.
    input wire logic       internalResistorSelect,
    input wire logic [5:0] contrastVolumeSetting,
    input wire logic [5:0] contrastLevel,
    input wire logic [2:0] regulatorRatioSetting,
    input wire logic [2:0] regulatorGainStep,
    input wire logic       internalDividerEnable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    AST_OSC_RUN: assert property (oscillatorRunning == (masterSelectInput && internalClockSelect))
        else $error("oscillator state does not follow the selects");
    AST_EXT_TICK: assert property (!oscillatorRunning && $rose(externalDisplayClockPin)
            |-> ##[1:6] lineStrobe)
        else $error("external clock edge gave no line strobe");
    AST_STROBE_STEP: assert property ($changed(commonIndex) |-> lineStrobe)
        else $error("common index moved without a line strobe");
    AST_STROBE_PULSE: assert property (lineStrobe |=> !lineStrobe)
        else $error("line strobe longer than one cycle");
    AST_COMMON_RANGE: assert property (commonIndex <= 7'h40)
        else $error("common index beyond the scanned rows");
    AST_POLARITY: assert property ($changed(drivePolaritySignal) |-> lineStrobe && commonIndex == 7'h40)
        else $error("polarity changed away from a frame wrap");
    AST_RD_HOLD: assert property ($changed(hostRdData) |-> hostRdValid)
        else $error("read data changed without a read pulse");
    AST_RD_ANSWER: assert property (hostValid && hostReady && hostIsData && hostIsRead
            |-> ##[2:40] hostRdValid)
        else $error("read request never answered");
    AST_CONTRAST: assert property (contrastLevel == 6'h3F - contrastVolumeSetting)
        else $error("contrast level is not 63 minus the setting");
    AST_GAIN: assert property (regulatorGainStep
            == (internalResistorSelect ? regulatorRatioSetting : 3'h0))
        else $error("gain step does not follow the ratio setting");
    AST_DIVIDER: assert property (internalDividerEnable == internalResistorSelect)
        else $error("divider enable does not follow the resistor select");
endmodule

bind ldc_display ldc_display_monitor u_monitor (.*);

/* sim/ldc_host_model.sv */
// Host processor model that drives the controller's command and data port.
`timescale 1ns/10ps
module ldc_host_model (
    // Clock.
    input  wire logic       mclk,
    // Request side.
    output logic            hostValid,
    output logic            hostIsData,
    output logic            hostIsRead,
    output logic [7:0]      hostWrData,
    // Answer side.
    input  wire logic       hostReady,
    input  wire logic [7:0] hostRdData,
    input  wire logic       hostRdValid
);
    int stalls = 0;

    initial begin
        hostValid = 1'b0;
        hostIsData = 1'b0;
        hostIsRead = 1'b0;
        hostWrData = 8'h00;
    end

    // Holds the request until an edge finds the queue open; callers start just after an edge.
    task automatic send(input logic isData, input logic isRead, input logic [7:0] value);
        int n;
        hostValid = 1'b1;
        hostIsData = isData;
        hostIsRead = isRead;
        hostWrData = value;
        n = 0;
        @(negedge mclk);
        while (hostReady !== 1'b1 && n < 64) begin
            @(negedge mclk);
            n++;
        end
        if (n == 64) stalls++;
        @(posedge mclk);
        #1;
    endtask

    // Releases the port; the data lines stop showing the last value.
    task automatic rest();
        hostValid = 1'b0;
        hostWrData = ~hostWrData;
        @(posedge mclk);
        #1;
    endtask

    task automatic read(output logic [7:0] value);
        int n;
        send(1'b1, 1'b1, 8'h00);
        hostValid = 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (hostRdValid !== 1'b1 && n < 64);
        if (hostRdValid !== 1'b1) stalls++;
        value = hostRdData;
    endtask
endmodule

/* sim/tb_ldc_display.sv */
// Self-checking bench for the display memory and scan controller.
`timescale 1ns/10ps
`include "ldc_consts.svh"
module tb_ldc_display
    import ldc_pkg::*;
;
    logic         mclk, arst_n, hostValid, hostReady, hostIsData, hostIsRead, hostRdValid;
    logic [7:0]   hostWrData, hostRdData;
    logic         masterSelectInput, internalClockSelect, externalDisplayClockPin, oscillatorRunning;
    logic [131:0] segmentOutput;
    logic [6:0]   commonIndex;
    logic         lineStrobe, drivePolaritySignal, internalResistorSelect, internalDividerEnable;
    logic [5:0]   contrastVolumeSetting, contrastLevel;
    logic [2:0]   regulatorRatioSetting, regulatorGainStep;
    int           badCount = 0;
    int           checks = 0;
    int           toggles = 0;
    ldc_byte_type cfg [5][5] = '{'{8'hAF, 8'hA0, 8'hA6, 8'hA4, 8'hC0}, '{8'hAF, 8'hA0, 8'hA7, 8'hA4, 8'hC0},
                                 '{8'hAF, 8'hA1, 8'hA6, 8'hA4, 8'hC8}, '{8'hAF, 8'hA0, 8'hA6, 8'hA5, 8'hC0},
                                 '{8'hAE, 8'hA0, 8'hA6, 8'hA4, 8'hC0}};

    ldc_display dut (.*);
    ldc_host_model host (.*);

    always #20 mclk = ~mclk;

    task automatic summarize();
        badCount += host.stalls;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmd(input ldc_byte_type b);
        host.send(1'b0, 1'b0, b);
    endtask

    task automatic wr(input ldc_byte_type b);
        host.send(1'b1, 1'b0, b);
    endtask

    task automatic idle();
        host.rest();
        if (host.stalls != 0) summarize();
    endtask

    task automatic rdchk(input ldc_byte_type e);
        ldc_byte_type r;
        host.read(r);
        if (host.stalls != 0) summarize();
        cmp8(r, e);
    endtask

    task automatic setpc(input logic [3:0] p, input logic [7:0] c);
        cmd({4'hB, p});
        cmd({4'h1, c[7:4]});
        cmd({4'h0, c[3:0]});
    endtask

    // Low period first, so back-to-back calls never drive the pin twice in one step.
    task automatic tick();
        int n;
        repeat (4) @(posedge mclk);
        #1 externalDisplayClockPin = 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (lineStrobe !== 1'b1 && n < 16);
        if (lineStrobe !== 1'b1) begin
            badCount++;
            summarize();
        end
        externalDisplayClockPin = 1'b0;
    endtask

    // Column 0 holds a single dot, in row 0.
    function automatic logic expSeg(int k, logic [6:0] ci, logic [5:0] s);
        int line;
        int row;
        line = (k == 2 && ci < 64) ? 63 - ci : ci;
        row = (s + line) % 65;
        case (k)
            1: return row != 0;
            3: return 1'b1;
            4: return 1'b0;
            default: return row == 0;
        endcase
    endfunction

    initial begin
        ldc_byte_type d [4];
        ldc_byte_type a;
        ldc_byte_type e;
        logic [3:0]   p;
        logic [7:0]   c;
        logic [5:0]   v;
        logic [5:0]   s;
        logic         pl;
        mclk = 1'b0;
        arst_n = 1'b0;
        masterSelectInput = 1'b1;
        internalClockSelect = 1'b0;
        externalDisplayClockPin = 1'b0;
        internalResistorSelect = 1'b1;
        void'($urandom(32'hDEAD));
        repeat (5) @(posedge mclk);
        #1 arst_n = 1'b1;
        cmp8({2'b00, contrastVolumeSetting}, {2'b00, `LDC_RST_VOLUME});
        cmp8({5'b0, regulatorRatioSetting}, {5'b0, `LDC_RST_RATIO});
        cmp1(drivePolaritySignal, 1'b0);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            masterSelectInput = k[0];
            internalClockSelect = k[1];
            @(posedge mclk);
            #1;
            cmp1(oscillatorRunning, k == 3);
        end
        internalClockSelect = 1'b0;
        masterSelectInput = 1'b1;
        $display("test clock select done");
        for (int k = 0; k < 8; k++) begin
            v = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($urandom);
            internalResistorSelect = k[0];
            cmd(8'h81);
            cmd({2'b00, v});
            cmd(8'h20 | 8'(k));
            idle();
            cmp8({2'b00, contrastLevel}, 8'(63 - v));
            cmp8({5'b0, regulatorGainStep}, k[0] ? 8'(k) : 8'h00);
            cmp1(internalDividerEnable, k[0]);
        end
        $display("test regulator done");
        p = 4'($urandom_range(7));
        c = 8'($urandom_range(123, 1));
        setpc(p, c);
        foreach (d[i]) begin
            d[i] = 8'($urandom);
            wr(d[i]);
        end
        cmd({4'h1, c[7:4]});
        cmd({4'h0, c[3:0]});
        foreach (d[i]) rdchk(d[i]);
        a = 8'($urandom);
        e = ~a;
        setpc(p, 8'h82);
        wr(a);
        wr(8'h5A);
        wr(e);
        setpc(p, 8'h82);
        rdchk(a);
        rdchk(e);
        rdchk(e);
        setpc(`LDC_INDICATOR_PAGE, c);
        wr(8'hFF);
        setpc(`LDC_INDICATOR_PAGE, c);
        rdchk(8'h01);
        setpc(4'h9, c);
        rdchk(8'h00);
        $display("test memory done");
        for (int k = 0; k <= 8; k++) begin
            setpc(4'(k), 8'h00);
            wr((k == 0) ? 8'h01 : 8'h00);
        end
        for (int k = 0; k < 5; k++) begin
            s = 6'($urandom);
            for (int j = 0; j < 5; j++) cmd(cfg[k][j]);
            cmd({2'b01, s});
            idle();
            for (int t = 0; t < 65; t++) begin
                pl = drivePolaritySignal;
                tick();
                if (drivePolaritySignal !== pl) toggles++;
                cmp1(segmentOutput[(k == 2) ? 131 : 0], expSeg(k, commonIndex, s));
            end
        end
        cmp8(8'(toggles), 8'h05);
        setpc(4'h0, 8'h00);
        rdchk(8'h01);
        $display("test scan done");
        summarize();
    end
endmodule
